// File: mode_decode_pkg.sv
// Purpose: Shared constants for the control-mode strap decoder.
// Assumes: Avalon-MM registers at word-aligned byte offsets.
// Notes: Offsets and status bit positions are the software view.
package mode_decode_pkg;

   // ==========================================================
   // Strap levels
   typedef enum logic [1:0] {
      LVL_LOW,
      LVL_MID,
      LVL_HIGH
   } strap_level_t;

   // ==========================================================
   // Strap pin indices
   localparam int NUM_STRAPS = 4;
   localparam int PIN_ECE = 0;
   localparam int PIN_FSR = 1;
   localparam int PIN_STYLE = 2;
   localparam int PIN_CALIBRATION_DELAY_SELECT = 3;

   // ==========================================================
   // Register map
   localparam logic [3:0] OFS_STATUS = 4'h0;
   localparam logic [3:0] OFS_CONTROL = 4'h4;
   localparam logic [3:0] OFS_FSADJ = 4'h8;
   localparam logic [3:0] OFS_LEVELS = 4'hC;

   // Status bit positions
   localparam int ST_EXT_ACTIVE = 0;
   localparam int ST_DIFF_RESET = 1;
   localparam int ST_FS_HIGH = 2;
   localparam int ST_CAL_ACTIVE = 3;
   localparam int ST_DES = 4;
   localparam int ST_FS_WRITABLE = 5;
   localparam int ST_CAL_LONG = 6;
   localparam int ST_CAL_PENDING = 7;

   // Control bit positions
   localparam int CT_CAL_START = 0;

   // ==========================================================
   // Reset values and counts
   localparam logic [7:0] FSADJ_RESET = 8'h80;
   localparam int FSADJ_WIDTH = 8;
   localparam int CAL_DELAY_SHORT_CYCLES = 1024;
   localparam int CAL_DELAY_LONG_CYCLES = 65536;
   localparam int CAL_RUN_CYCLES = 2048;
   localparam int COUNT_WIDTH = 32;

endpackage

// File: strap_level_sync.sv
// Purpose: Resolve three-level strap pins into low, mid or high.
// Assumes: Each pin has two comparator outputs, above and below.
// Notes: Both comparator bits pass two flip-flops before decode.
`timescale 1ns/100ps
`default_nettype none
module strap_level_sync
   import mode_decode_pkg::*;
#(
   parameter int N = NUM_STRAPS
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [N-1:0] pinAbove,
   input wire logic [N-1:0] pinBelow,
   output logic [2*N-1:0] levelCode
);

   logic [N-1:0] aboveMeta_reg;
   logic [N-1:0] belowMeta_reg;
   logic [N-1:0] aboveSync_reg;
   logic [N-1:0] belowSync_reg;
   logic [2*N-1:0] levelCode_reg;

   // ==========================================================
   // Synchronisers
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         aboveMeta_reg <= '0;
         belowMeta_reg <= '0;
         aboveSync_reg <= '0;
         belowSync_reg <= '0;
      end else begin
         aboveMeta_reg <= pinAbove;
         belowMeta_reg <= pinBelow;
         aboveSync_reg <= aboveMeta_reg;
         belowSync_reg <= belowMeta_reg;
      end
   end

   // ==========================================================
   // Per-pin level decode
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_pin
         // Neither threshold crossed means floating or half supply
         wire strap_level_t lvl = aboveSync_reg[i] ? LVL_HIGH :
            (belowSync_reg[i] ? LVL_LOW : LVL_MID); // R13
         always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
               levelCode_reg[2*i+1:2*i] <= LVL_MID;
            end else begin
               levelCode_reg[2*i+1:2*i] <= lvl;
            end
         end
      end
   endgenerate

   assign levelCode = levelCode_reg;

endmodule // strap_level_sync
`default_nettype wire

// File: mode_pin_decode.sv
// Purpose: Control-mode strap decode, calibration sequencing, regs.
// Assumes: core_clk 50 MHz; straps sensed by threshold comparators.
// Notes: Avalon-MM slave, one wait state on every access.
//
// What this block does and what it expects of the host
// (R1) Calibration-active output is high exactly while calibration runs.
// (R2) Dedicated enable high disables extended control, pins only.
// (R3) Dedicated enable low activates extended control.
// (R4) Dedicated enable outranks the alternate enable on the shared pin.
// (R5) Style selector high or floating gives single-ended reset, FULL_SCALE_SELECT pin.
// (R6) Style selector low makes reset differential, shared pin negative.
// (R7) Differential reset mode forces the higher full-scale range.
// (R8) Full-scale adjust is writable while dedicated enable is low.
// (R9) Range comes from the pin in pin mode, register in extended mode.
// (R10) Pin low selects reduced range, pin high the higher range.
// (R11) Shared pin floating or mid enables extended control if allowed.
// (R12) Extended mode turns delay pin into chip select, short delay.
// (R13) Each strap resolves to high, low or mid and decodes continuously.
// (R14) The host keeps straps stable while calibration is reported.
//
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module mode_pin_decode
   import mode_decode_pkg::*;
#(
   parameter int CAL_DELAY_LONG = CAL_DELAY_LONG_CYCLES,
   parameter int CAL_DELAY_SHORT = CAL_DELAY_SHORT_CYCLES,
   parameter int CAL_RUN = CAL_RUN_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst,
   // Avalon-MM slave
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Strap comparators
   input wire logic extControlEnableNAbove,
   input wire logic extControlEnableNBelow,
   input wire logic fullScaleSelectAbove,
   input wire logic fullScaleSelectBelow,
   input wire logic clockResetStyleSelectAbove,
   input wire logic clockResetStyleSelectBelow,
   input wire logic calibrationDelaySelectAbove,
   input wire logic calibrationDelaySelectBelow,
   input wire logic outputClockResetPos,
   // Decoded outputs
   output logic calibrationActiveFlag,
   output logic extendedControlActive,
   output logic diffClockReset,
   output logic fullScaleHigh,
   output logic [FSADJ_WIDTH-1:0] fullScaleAdjust,
   output logic useFullScaleAdjust,
   output logic dualEdgeSampling,
   output logic serialChipSelectN,
   output logic outputClockReset
);

   // ==========================================================
   // Strap resolution
   logic [2*NUM_STRAPS-1:0] levelCode;
   strap_level_t eceLvl;
   strap_level_t fsrLvl;
   strap_level_t styleLvl;
   strap_level_t dlyLvl;

   strap_level_sync #(
      .N(NUM_STRAPS)
   ) u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .pinAbove({calibrationDelaySelectAbove, clockResetStyleSelectAbove,
         fullScaleSelectAbove, extControlEnableNAbove}),
      .pinBelow({calibrationDelaySelectBelow, clockResetStyleSelectBelow,
         fullScaleSelectBelow, extControlEnableNBelow}),
      .levelCode(levelCode)
   );

   assign eceLvl = strap_level_t'(levelCode[2*PIN_ECE+:2]);
   assign fsrLvl = strap_level_t'(levelCode[2*PIN_FSR+:2]);
   assign styleLvl = strap_level_t'(levelCode[2*PIN_STYLE+:2]);
   assign dlyLvl = strap_level_t'(levelCode[2*PIN_CALIBRATION_DELAY_SELECT+:2]);

   // Reset positive leg is a plain two-level pin
   logic rstPosMeta_reg;
   logic rstPosSync_reg;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rstPosMeta_reg <= 1'b0;
         rstPosSync_reg <= 1'b0;
      end else begin
         rstPosMeta_reg <= outputClockResetPos;
         rstPosSync_reg <= rstPosMeta_reg;
      end
   end

   // ==========================================================
   // Mode decode
   wire diffMode = (styleLvl == LVL_LOW); // R6
   wire singleMode = !diffMode; // R5
   wire eceForcesOn = (eceLvl == LVL_LOW); // R3
   wire eceForcesOff = (eceLvl == LVL_HIGH); // R2
   // Alternate enable only exists while the shared pin is not a reset leg
   wire altEnable = singleMode && (fsrLvl == LVL_MID); // R11
   wire extActive = eceForcesOn ||
      (!eceForcesOff && altEnable); // R4
   wire fsWritable = eceForcesOn; // R8
   // Mid level on the shared pin has no range meaning; keep high
   wire pinRangeHigh = diffMode ? 1'b1 : // R7
      (fsrLvl != LVL_LOW); // R10
   // Delay pin mid selects dual-edge sampling in pin mode only
   wire desSelect = !extActive && (dlyLvl == LVL_MID);
   wire calLongPin = (dlyLvl == LVL_HIGH);
   wire calLong = calLongPin && !extActive; // R12
   wire diffResetLevel = rstPosSync_reg && (fsrLvl == LVL_LOW);
   wire resetLevel = diffMode ? diffResetLevel : rstPosSync_reg; // R5 R6

   // ==========================================================
   // Bus decode
   logic respPhase_reg;
   logic [31:0] readdata_reg;
   logic [FSADJ_WIDTH-1:0] fsAdj_reg;
   logic calStartPending_reg;

   wire busReq = read || write;
   wire accept = busReq && respPhase_reg;
   wire selStatus = (address == OFS_STATUS);
   wire selControl = (address == OFS_CONTROL);
   wire selFsAdj = (address == OFS_FSADJ);
   wire selLevels = (address == OFS_LEVELS);
   wire fsAdjWrite = accept && write && selFsAdj && fsWritable; // R8
   wire calStartWrite = accept && write && selControl &&
      writedata[CT_CAL_START];

   assign waitrequest = busReq && !respPhase_reg;

   // ==========================================================
   // Calibration sequencer
   typedef enum logic [1:0] {
      CAL_WAIT,
      CAL_RUNNING,
      CAL_IDLE
   } cal_state_t;

   cal_state_t calState_reg;
   cal_state_t calState_next;
   logic [COUNT_WIDTH-1:0] calCount_reg;
   logic [COUNT_WIDTH-1:0] calCount_next;
   logic calPending_next;

   wire [COUNT_WIDTH-1:0] delayTarget = calLong ?
      COUNT_WIDTH'(CAL_DELAY_LONG - 1) :
      COUNT_WIDTH'(CAL_DELAY_SHORT - 1); // R12
   wire [COUNT_WIDTH-1:0] runTarget = COUNT_WIDTH'(CAL_RUN - 1);
   // One incrementer shared by both counting states
   wire [COUNT_WIDTH-1:0] countInc = calCount_reg + COUNT_WIDTH'(1);

   always_comb begin
      calState_next = calState_reg;
      calCount_next = calCount_reg;
      // Request made mid-run is kept and served afterwards
      calPending_next = calStartPending_reg || calStartWrite;
      case (calState_reg)
         CAL_WAIT: begin
            if (calCount_reg >= delayTarget) begin
               calState_next = CAL_RUNNING;
               calCount_next = '0;
            end else begin
               calCount_next = countInc;
            end
         end
         CAL_RUNNING: begin
            if (calCount_reg >= runTarget) begin
               calState_next = CAL_IDLE;
               calCount_next = '0;
            end else begin
               calCount_next = countInc;
            end
         end
         CAL_IDLE: begin
            // A held request skips the power-up wait
            if (calStartPending_reg) begin
               calState_next = CAL_RUNNING;
               calCount_next = '0;
               calPending_next = calStartWrite;
            end
         end
         default: begin
            calState_next = CAL_IDLE;
            calCount_next = '0;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         calState_reg <= CAL_WAIT;
         calCount_reg <= '0;
         calStartPending_reg <= 1'b0;
      end else begin
         calState_reg <= calState_next;
         calCount_reg <= calCount_next;
         calStartPending_reg <= calPending_next;
      end
   end

   // ==========================================================
   // Registers and read data
   logic [31:0] statusWord;
   logic [31:0] readMux;

   always_comb begin
      statusWord = '0;
      statusWord[ST_EXT_ACTIVE] = extActive;
      statusWord[ST_DIFF_RESET] = diffMode;
      statusWord[ST_FS_HIGH] = fullScaleHigh;
      statusWord[ST_CAL_ACTIVE] = calibrationActiveFlag;
      statusWord[ST_DES] = desSelect;
      statusWord[ST_FS_WRITABLE] = fsWritable;
      statusWord[ST_CAL_LONG] = calLong;
      statusWord[ST_CAL_PENDING] = calStartPending_reg;
   end

   assign readMux = selStatus ? statusWord :
      selFsAdj ? {{(32-FSADJ_WIDTH){1'b0}}, fsAdj_reg} :
      selLevels ? {{(32-2*NUM_STRAPS){1'b0}}, levelCode} :
      32'h00000000;

   // One fixed wait state keeps read data registered
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         respPhase_reg <= 1'b0;
         readdata_reg <= 32'h00000000;
      end else begin
         respPhase_reg <= busReq && !respPhase_reg;
         if (read && !respPhase_reg) begin
            readdata_reg <= readMux;
         end
      end
   end

   // Write ignored while pins lock the adjust register
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         fsAdj_reg <= FSADJ_RESET;
      end else if (fsAdjWrite) begin
         fsAdj_reg <= writedata[FSADJ_WIDTH-1:0];
      end
   end

   // ==========================================================
   // Registered outputs
   logic calActive_reg;
   logic extActive_reg;
   logic diffMode_reg;
   logic fsHigh_reg;
   logic useAdj_reg;
   logic des_reg;
   logic csN_reg;
   logic clkRst_reg;

   // Registered so the board never sees decode glitches
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         calActive_reg <= 1'b0;
         extActive_reg <= 1'b0;
         diffMode_reg <= 1'b0;
         fsHigh_reg <= 1'b1;
         useAdj_reg <= 1'b0;
         des_reg <= 1'b0;
         csN_reg <= 1'b1;
         clkRst_reg <= 1'b0;
      end else begin
         calActive_reg <= (calState_next == CAL_RUNNING); // R1
         extActive_reg <= extActive; // R13
         diffMode_reg <= diffMode;
         fsHigh_reg <= pinRangeHigh; // R9
         useAdj_reg <= extActive; // R9
         des_reg <= desSelect;
         // Chip select follows the delay pin only in extended mode
         csN_reg <= extActive ? (dlyLvl != LVL_LOW) : 1'b1; // R12
         clkRst_reg <= resetLevel;
      end
   end

   assign calibrationActiveFlag = calActive_reg;
   assign extendedControlActive = extActive_reg;
   assign diffClockReset = diffMode_reg;
   assign fullScaleHigh = fsHigh_reg;
   assign useFullScaleAdjust = useAdj_reg;
   assign fullScaleAdjust = fsAdj_reg;
   assign dualEdgeSampling = des_reg;
   assign serialChipSelectN = csN_reg;
   assign outputClockReset = clkRst_reg;
   assign readdata = readdata_reg;

endmodule // mode_pin_decode
`default_nettype wire

// File: mode_pin_decode_sva.sv
// Purpose: Port assertions for the control-mode strap decoder.
// Assumes: Strap changes reach outputs after 4 edges.
// Notes: Strap checks wait 7 edges after reset release.
`timescale 1ns/100ps
`default_nettype none
module mode_pin_decode_sva
   import mode_decode_pkg::*;
#(
   parameter int CAL_RUN = CAL_RUN_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [3:0] address,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic waitrequest,
   input wire logic extControlEnableNAbove,
   input wire logic extControlEnableNBelow,
   input wire logic fullScaleSelectAbove,
   input wire logic fullScaleSelectBelow,
   input wire logic clockResetStyleSelectAbove,
   input wire logic clockResetStyleSelectBelow,
   input wire logic calibrationDelaySelectAbove,
   input wire logic calibrationDelaySelectBelow,
   input wire logic calibrationActiveFlag,
   input wire logic extendedControlActive,
   input wire logic diffClockReset,
   input wire logic fullScaleHigh,
   input wire logic [FSADJ_WIDTH-1:0] fullScaleAdjust,
   input wire logic useFullScaleAdjust,
   input wire logic serialChipSelectN
);
   // ==========
   // Helpers
   logic [2:0] age;
   logic [15:0] runCnt;
   // Synchronisers read MID just after reset
   wire logic ok = age == 3'h7;
   wire logic eceHi = extControlEnableNAbove;
   wire logic eceLo = !eceHi && extControlEnableNBelow;
   wire logic fsLo = !fullScaleSelectAbove && fullScaleSelectBelow;
   wire logic fsMid = !fullScaleSelectAbove && !fullScaleSelectBelow;
   wire logic stLo = !clockResetStyleSelectAbove && clockResetStyleSelectBelow;
   wire logic dlyLo = !calibrationDelaySelectAbove &&
      calibrationDelaySelectBelow;
   wire logic prio = eceHi && fsMid && !stLo;
   wire logic altOn = !eceHi && !eceLo && fsMid && !stLo;
   wire logic fsWr = write && !waitrequest && address == OFS_FSADJ;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         age <= 3'h0;
         runCnt <= 16'h0;
      end else begin
         age <= ok ? age : age + 3'h1;
         runCnt <= calibrationActiveFlag ? runCnt + 16'h1 : 16'h0;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // Write enable is decoded one edge before the registered outputs
   sequence fsOpen;
      ok && fsWr && $past(eceLo, 3);
   endsequence
   sequence fsShut;
      ok && fsWr && !$past(eceLo, 3);
   endsequence
   // ==========
   // Assertions
   a_ext_pins_only: assert property (ok && $past(eceHi, 4)
      |-> !extendedControlActive) else $error("ext mode with enable high");
   a_ext_enabled: assert property (ok && $past(eceLo, 4)
      |-> extendedControlActive) else $error("ext mode off with enable low");
   a_ece_priority: assert property (ok && $past(prio, 4)
      |-> !extendedControlActive) else $error("alternate enable won");
   a_alt_enable: assert property (ok && $past(altOn, 4)
      |-> extendedControlActive) else $error("alternate enable ignored");
   a_reset_style: assert property (ok
      |-> diffClockReset == $past(stLo, 4)) else $error("reset style wrong");
   a_diff_range: assert property (ok && diffClockReset
      |-> fullScaleHigh) else $error("differential mode not high range");
   a_pin_range: assert property (ok && !diffClockReset
      && !extendedControlActive |-> fullScaleHigh == !$past(fsLo, 4))
      else $error("pin range wrong");
   a_range_source: assert property (ok
      |-> useFullScaleAdjust == $past(eceLo || altOn, 4))
      else $error("range source wrong");
   a_chip_select: assert property (ok |-> serialChipSelectN ==
      !(extendedControlActive && $past(dlyLo, 4)))
      else $error("chip select wrong");
   a_fs_write: assert property (fsOpen |=>
      fullScaleAdjust == $past(writedata[7:0])) else $error("adjust not set");
   a_fs_locked: assert property (fsShut |=> $stable(fullScaleAdjust))
      else $error("adjust written in pin mode");
   a_cal_length: assert property ($fell(calibrationActiveFlag)
      |-> int'(runCnt) == CAL_RUN) else $error("calibration length wrong");
   a_cal_bound: assert property (int'(runCnt) <= CAL_RUN)
      else $error("calibration too long");
endmodule // mode_pin_decode_sva
bind mode_pin_decode mode_pin_decode_sva #(.CAL_RUN(CAL_RUN)) u_sva (
   .core_clk, .rst, .address, .write, .writedata, .waitrequest,
   .extControlEnableNAbove, .extControlEnableNBelow,
   .fullScaleSelectAbove, .fullScaleSelectBelow,
   .clockResetStyleSelectAbove, .clockResetStyleSelectBelow,
   .calibrationDelaySelectAbove, .calibrationDelaySelectBelow,
   .calibrationActiveFlag, .extendedControlActive, .diffClockReset,
   .fullScaleHigh, .fullScaleAdjust, .useFullScaleAdjust,
   .serialChipSelectN);
`default_nettype wire

// File: strap_host_model.sv
// Purpose: Board host driving the four mode straps.
// Assumes: Each strap seen as an above/below comparator pair.
// Notes: New levels wait while calibration is reported.
`timescale 1ns/100ps
`default_nettype none
module strap_host_model
   import mode_decode_pkg::*;
(
   input wire logic core_clk,
   input wire logic [7:0] wantLevels,
   input wire logic calBusy,
   output logic [3:0] above,
   output logic [3:0] below
);
   // ==========
   // Strap drive
   initial begin
      above = 4'h0;
      below = 4'h0;
   end
   always @(posedge core_clk) begin
      // Mode must not move under a running calibration
      if (!calBusy) begin
         for (int i = 0; i < NUM_STRAPS; i++) begin
            above[i] <= wantLevels[2*i+:2] == LVL_HIGH;
            below[i] <= wantLevels[2*i+:2] == LVL_LOW;
         end
      end
   end
endmodule // strap_host_model
`default_nettype wire

// File: test_mode_pin_decode.sv
// Purpose: Self-checking bench for the strap decoder.
// Assumes: Shortened calibration counts 40, 20 and 16.
// Notes: Random strap mixes plus three corner mixes.
`timescale 1ns/100ps
`default_nettype none
module test_mode_pin_decode;
   import mode_decode_pkg::*;
   localparam int RUN = 16;
   localparam logic [7:0] CORNER [3] = '{8'h26, 8'h65, 8'h05};
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] address = 4'h0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic outputClockResetPos = 1'b0;
   logic [7:0] wantLevels = 8'h22;
   logic [31:0] seed = 32'h00012E2B;
   logic [31:0] readdata, rdv;
   logic [3:0] above, below;
   logic waitrequest, calibrationActiveFlag, extendedControlActive;
   logic diffClockReset, fullScaleHigh, useFullScaleAdjust;
   logic serialChipSelectN, dualEdgeSampling, outputClockReset;
   logic [FSADJ_WIDTH-1:0] fullScaleAdjust;
   int n_mismatch = 0;
   int tests_run = 0;
   int cycles = 0;
   // Pin range is undefined in extended mode, so masked there
   wire logic [4:0] seenModes = {extendedControlActive, diffClockReset,
      fullScaleHigh | extendedControlActive, useFullScaleAdjust,
      serialChipSelectN};
   mode_pin_decode #(
      .CAL_DELAY_LONG(40),
      .CAL_DELAY_SHORT(20),
      .CAL_RUN(RUN)
   ) u_mode_pin_decode (
      .core_clk, .rst, .address, .read, .write, .writedata, .readdata,
      .waitrequest, .extControlEnableNAbove(above[0]),
      .extControlEnableNBelow(below[0]), .fullScaleSelectAbove(above[1]),
      .fullScaleSelectBelow(below[1]),
      .clockResetStyleSelectAbove(above[2]),
      .clockResetStyleSelectBelow(below[2]),
      .calibrationDelaySelectAbove(above[3]),
      .calibrationDelaySelectBelow(below[3]), .outputClockResetPos,
      .calibrationActiveFlag, .extendedControlActive, .diffClockReset,
      .fullScaleHigh, .fullScaleAdjust, .useFullScaleAdjust,
      .dualEdgeSampling, .serialChipSelectN, .outputClockReset);
   strap_host_model u_strap_host_model (.core_clk, .wantLevels,
      .calBusy(calibrationActiveFlag), .above, .below);
   // ==========
   // Helpers
   always #10 core_clk = ~core_clk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [4:0] expectModes(input logic [7:0] lv);
      logic ext;
      logic diff;
      ext = lv[1:0] == 2'h0 ||
         (lv[1:0] == 2'h1 && lv[3:2] == 2'h1 && lv[5:4] != 2'h0);
      diff = lv[5:4] == 2'h0;
      return {ext, diff, ext || diff || lv[3:2] != 2'h0, ext,
         !(ext && lv[7:6] == 2'h0)};
   endfunction
   task automatic check(input string what, input logic [31:0] seen,
         input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a,
         input logic [31:0] d);
      @(posedge core_clk);
      address <= a;
      write <= wr;
      read <= !wr;
      writedata <= d;
      do @(posedge core_clk); while (waitrequest !== 1'b0);
      rdv = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic calibration_active_flag(output int lag);
      int len;
      lag = 0;
      len = 0;
      while (calibrationActiveFlag !== 1'b1) begin
         @(posedge core_clk);
         lag++;
      end
      while (calibrationActiveFlag === 1'b1) begin
         @(posedge core_clk);
         len++;
      end
      check("cal length", len, RUN);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         results();
      end
   end
   // ==========
   // Main sequence
   initial begin
      logic [7:0] lv;
      logic [7:0] fsa;
      logic [31:0] wd;
      logic [4:0] em;
      int lag;
      fsa = FSADJ_RESET;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      check("adjust reset", fullScaleAdjust, FSADJ_RESET);
      calibration_active_flag(lag);
      for (int i = 0; i < 40; i++) begin
         wd = rnd();
         for (int j = 0; j < 4; j++)
            lv[2*j+:2] = 2'(rnd() % 3);
         if (i < 3)
            lv = CORNER[i];
         wantLevels <= lv;
         outputClockResetPos <= wd[8];
         repeat (8) @(posedge core_clk);
         em = expectModes(lv);
         check("modes", seenModes, em);
         check("des", dualEdgeSampling, !em[4] && lv[7:6] == 2'h1);
         check("ocr", outputClockReset, wd[8] & (!em[3] | ~|lv[3:2]));
         bus(1'b0, OFS_STATUS, 32'h0);
         check("status", rdv, {24'h0, 1'b0,
            lv[7:6] == 2'h2 && !em[4], lv[1:0] == 2'h0,
            !em[4] && lv[7:6] == 2'h1, 1'b0,
            em[3] || lv[3:2] != 2'h0, em[3], em[4]});
         bus(1'b0, OFS_LEVELS, 32'h0);
         check("levels", rdv, {24'h0, lv});
         bus(1'b1, OFS_FSADJ, wd);
         if (lv[1:0] == 2'h0)
            fsa = wd[7:0];
         bus(1'b0, OFS_FSADJ, 32'h0);
         check("adjust reg", rdv, {24'h0, fsa});
         check("adjust port", fullScaleAdjust, fsa);
      end
      bus(1'b0, 4'h2, 32'h0);
      check("unmapped", rdv, 32'h0);
      bus(1'b1, OFS_CONTROL, 32'h1);
      calibration_active_flag(lag);
      check("cal start", lag, 2);
      // Second start lands mid-run and must be served after it
      bus(1'b1, OFS_CONTROL, 32'h1);
      bus(1'b1, OFS_CONTROL, 32'h1);
      while (calibrationActiveFlag === 1'b1) @(posedge core_clk);
      calibration_active_flag(lag);
      check("cal pending", lag, 1);
      results();
   end
endmodule // test_mode_pin_decode
`default_nettype wire
